// [hdl/vapc_pkg.sv]
// What this block does
// - lock bit set: ignore remote loads
// - remote load overwrites bits 6..0 unlocked
// - bypass forwards pixels regardless of enable
// - bypass disables protection, blocks packetized audio
// - bit5 one: enable active low
// - bit4 one: no audio on pixel pins
// - override selects bit0, else four-channel off
// - bit0 enables four-channel audio output
// - bit2 one: 18-bit, zero: 24-bit
// - bit1 one: in-band, zero: data-island
// - register at 0x22, resets zero, RW
package vapc_pkg;
  localparam logic [11:0] VAPC_CFG_OFFSET  = 12'h0022;     // config register index
  localparam logic [11:0] VAPC_STAT_OFFSET = 12'h0024;     // own status register index
  // word index, so each register sits on its own word: byte address is four times the index
  localparam logic [11:0] VAPC_CFG_ADDR    = {VAPC_CFG_OFFSET[9:0], 2'b00};  // config byte address
  localparam logic [11:0] VAPC_STAT_ADDR   = {VAPC_STAT_OFFSET[9:0], 2'b00}; // status byte address
  localparam logic [7:0]  VAPC_CFG_RESET   = 8'h00;        // config reset value
  localparam int          VAPC_LOCK_BIT    = 7;            // remote load lock
  localparam int          VAPC_BYP_BIT     = 6;            // pixel gate bypass
  localparam int          VAPC_SENSE_BIT   = 5;            // frame enable sense
  localparam int          VAPC_SUPP_BIT    = 4;            // audio suppress
  localparam int          VAPC_OVR_BIT     = 3;            // four-channel override
  localparam int          VAPC_D18_BIT     = 2;            // colour depth
  localparam int          VAPC_INB_BIT     = 1;            // audio transport
  localparam int          VAPC_FOUR_BIT    = 0;            // four-channel enable
  localparam int          VAPC_PIX_W       = 24;           // pixel bus width
endpackage : vapc_pkg

// [hdl/vapc_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for pin levels
module vapc_sync #(parameter int W = 1) (
  input  wire logic         clk,   // system clock
  input  wire logic         rst_n, // async reset
  input  wire logic [W-1:0] d,     // async input
  output logic      [W-1:0] q      // synchronised output
);
  logic [W-1:0] meta_r; // first stage, read only by q
  // two stages, nothing taps the first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : vapc_sync
`default_nettype wire

// [hdl/vapc_pixel_gate.sv]
`timescale 1ns/1ps
`default_nettype none
// pixel forwarding stage, registered outputs
module vapc_pixel_gate
  import vapc_pkg::*;
(
  input  wire logic                  clk,       // system clock
  input  wire logic                  rst_n,     // async reset
  input  wire logic                  bypass,    // pixel gate bypass
  input  wire logic                  sense_low, // enable active low
  input  wire logic                  d18,       // 18-bit mode
  input  wire logic                  frm_en,    // synced frame enable
  input  wire logic [VAPC_PIX_W-1:0] pix_in,    // synced pixel data
  output logic      [VAPC_PIX_W-1:0] pix_out,   // forwarded pixels
  output logic                       pix_vld    // pixel valid
);
  logic active; // enable after polarity
  assign active = sense_low ? ~frm_en : frm_en;
  // forward framed or bypassed pixels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_out <= '0;
      pix_vld <= 1'b0;
    end else begin
      pix_vld <= bypass | active;
      if (bypass || active) begin
        // 18-bit mode drops two lsbs per colour
        pix_out <= d18 ? (pix_in & 24'hFC_FCFC) : pix_in;
      end else begin
        pix_out <= '0;
      end
    end
  end
endmodule : vapc_pixel_gate
`default_nettype wire

// [hdl/vapc_top.sv]
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// video/audio path config register with apb access and remote load
module vapc_top
  import vapc_pkg::*;
(
  input  wire logic                  clk,          // 40 MHz clock
  input  wire logic                  rst_n,        // async reset, low
  input  wire logic                  psel,         // apb select
  input  wire logic                  penable,      // apb enable
  input  wire logic                  pwrite,       // apb direction
  input  wire logic [11:0]           paddr,        // apb byte address
  input  wire logic [31:0]           pwdata,       // apb write data
  output logic      [31:0]           prdata,       // apb read data
  output logic                       pready,       // apb ready
  output logic                       pslverr,      // apb error
  input  wire logic                  fc_load,      // remote load pulse
  input  wire logic [6:0]            fc_data,      // remote field values
  input  wire logic                  frm_en_pin,   // frame enable pin
  input  wire logic [VAPC_PIX_W-1:0] pix_pin,      // pixel pins
  output logic      [VAPC_PIX_W-1:0] pix_out,      // forwarded pixels
  output logic                       pix_vld,      // pixel valid
  output logic                       prot_en,      // content protection on
  output logic                       audio_pkt_en, // packetized audio allowed
  output logic                       audio_on_pix, // audio on pixel pins
  output logic                       four_ch_en,   // four-channel i2s on
  output logic                       inband_sel    // in-band transport
);
  typedef struct packed {
    logic [7:0]  cfg;     // config register
    logic        fc_seen; // remote load accepted at least once
    logic [31:0] rdata;   // read data
    logic        ready;   // access answer
    logic        err;     // unmapped flag
    logic        prot;    // protection enable
    logic        apkt;    // packet audio enable
    logic        aopix;   // audio on pixels
    logic        four;    // four-channel
    logic        inb;     // transport
  } vapc_state_t;

  vapc_state_t st_r;   // registered state
  vapc_state_t st_nxt; // next state

  logic                  frm_en_s; // synced enable
  logic [VAPC_PIX_W-1:0] pix_s;    // synced pixels
  logic                  acc;      // access phase
  logic                  hit_cfg;  // cfg decode
  logic                  hit_stat; // status decode

  // pins pass two flops before use
  vapc_sync #(.W(1)) u_sync_en (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (frm_en_pin),
    .q     (frm_en_s)
  );
  vapc_sync #(.W(VAPC_PIX_W)) u_sync_pix (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pix_pin),
    .q     (pix_s)
  );

  // apb decode; answer one cycle into access phase
  assign acc      = psel & penable & ~st_r.ready;
  assign hit_cfg  = (paddr == VAPC_CFG_ADDR);
  assign hit_stat = (paddr == VAPC_STAT_ADDR);

  // next state
  always_comb begin
    st_nxt       = st_r;
    st_nxt.ready = 1'b0;
    st_nxt.err   = 1'b0;
    // remote load: one whole update of bits 6..0, skipped when locked
    if (fc_load && !st_r.cfg[VAPC_LOCK_BIT]) begin
      st_nxt.cfg[6:0] = fc_data;
      st_nxt.fc_seen  = 1'b1;
    end
    if (acc) begin
      st_nxt.ready = 1'b1;
      st_nxt.rdata = 32'h0000_0000;
      if (hit_cfg) begin
        // local write wins over a same-cycle remote load
        if (pwrite) begin
          st_nxt.cfg = pwdata[7:0];
        end else begin
          st_nxt.rdata = {24'h00_0000, st_r.cfg};
        end
      end else if (hit_stat) begin
        if (!pwrite) begin
          st_nxt.rdata = {30'h0000_0000, st_r.fc_seen, st_r.cfg[VAPC_LOCK_BIT]};
        end
      end else begin
        st_nxt.err = 1'b1; // unmapped address
      end
    end
    // datapath controls from the settled register
    st_nxt.prot  = ~st_r.cfg[VAPC_BYP_BIT];
    st_nxt.apkt  = ~st_r.cfg[VAPC_BYP_BIT];
    st_nxt.aopix = ~st_r.cfg[VAPC_SUPP_BIT] & ~st_r.cfg[VAPC_BYP_BIT];
    st_nxt.four  = st_r.cfg[VAPC_OVR_BIT] & st_r.cfg[VAPC_FOUR_BIT];
    st_nxt.inb   = st_r.cfg[VAPC_INB_BIT];
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r     <= '0;
      st_r.cfg <= VAPC_CFG_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  vapc_pixel_gate u_gate (
    .clk       (clk),
    .rst_n     (rst_n),
    .bypass    (st_r.cfg[VAPC_BYP_BIT]),
    .sense_low (st_r.cfg[VAPC_SENSE_BIT]),
    .d18       (st_r.cfg[VAPC_D18_BIT]),
    .frm_en    (frm_en_s),
    .pix_in    (pix_s),
    .pix_out   (pix_out),
    .pix_vld   (pix_vld)
  );

  assign prdata       = st_r.rdata;
  assign pready       = st_r.ready;
  assign pslverr      = st_r.err;
  assign prot_en      = st_r.prot;
  assign audio_pkt_en = st_r.apkt;
  assign audio_on_pix = st_r.aopix;
  assign four_ch_en   = st_r.four;
  assign inband_sel   = st_r.inb;

  // locked register ignores remote loads
  property p_lock_holds;
    @(posedge clk) disable iff (!rst_n)
    (st_r.cfg[VAPC_LOCK_BIT] && fc_load && !acc) |=> (st_r.cfg == $past(st_r.cfg));
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("locked cfg changed");

  property p_remote_load;
    @(posedge clk) disable iff (!rst_n)
    (!st_r.cfg[VAPC_LOCK_BIT] && fc_load && !acc) |=> (st_r.cfg[6:0] == $past(fc_data));
  endproperty
  a_remote_load: assert property (p_remote_load) else $error("remote load missed");

  property p_bypass_valid;
    @(posedge clk) disable iff (!rst_n)
    (st_r.cfg[VAPC_BYP_BIT] && $stable(st_r.cfg)) |=> pix_vld;
  endproperty
  a_bypass_valid: assert property (p_bypass_valid) else $error("bypass not forwarding");

  property p_bypass_prot;
    @(posedge clk) disable iff (!rst_n)
    st_r.cfg[VAPC_BYP_BIT] |=> (!prot_en && !audio_pkt_en);
  endproperty
  a_bypass_prot: assert property (p_bypass_prot) else $error("protection on in bypass");

  property p_sense;
    @(posedge clk) disable iff (!rst_n)
    (!st_r.cfg[VAPC_BYP_BIT] && $stable(st_r.cfg)) |=>
      (pix_vld == ($past(st_r.cfg[VAPC_SENSE_BIT]) ^ $past(frm_en_s)));
  endproperty
  a_sense: assert property (p_sense) else $error("enable polarity wrong");

  property p_suppress;
    @(posedge clk) disable iff (!rst_n)
    st_r.cfg[VAPC_SUPP_BIT] |=> !audio_on_pix;
  endproperty
  a_suppress: assert property (p_suppress) else $error("audio on pixel pins");

  property p_four;
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> (four_ch_en == ($past(st_r.cfg[VAPC_OVR_BIT]) & $past(st_r.cfg[VAPC_FOUR_BIT])));
  endproperty
  a_four: assert property (p_four) else $error("four-channel select wrong");

  property p_inband;
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> (inband_sel == $past(st_r.cfg[VAPC_INB_BIT]));
  endproperty
  a_inband: assert property (p_inband) else $error("transport select wrong");

  property p_write;
    @(posedge clk) disable iff (!rst_n)
    (acc && hit_cfg && pwrite) |=> (st_r.cfg == $past(pwdata[7:0])) ##0 pready;
  endproperty
  a_write: assert property (p_write) else $error("cfg write lost");

  property p_d18;
    @(posedge clk) disable iff (!rst_n)
    (st_r.cfg[VAPC_D18_BIT] && $stable(st_r.cfg)) |=> (pix_out[1:0] == 2'h0);
  endproperty
  a_d18: assert property (p_d18) else $error("18-bit lsbs not cleared");
endmodule : vapc_top
`default_nettype wire

// [bench/vapc_remote_ser.sv]
`timescale 1ns/1ps
`default_nettype none
// far-side serializer: sends one field update per request
module vapc_remote_ser (
  input  wire logic       clk,      // system clock
  input  wire logic       rst_n,    // async reset, low
  input  wire logic       req,      // send one update
  input  wire logic       compat,   // compatibility mode
  input  wire logic [6:0] req_data, // field values to send
  output logic            fc_load,  // update strobe
  output logic      [6:0] fc_data   // field values
);
  // strobe and fields launched together, one cycle long
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fc_load <= 1'b0;
      fc_data <= 7'h00;
    end else if (req) begin
      fc_load <= 1'b1;                                        // whole update in one strobe
      fc_data <= compat ? (req_data & 7'h3f) : req_data;      // bypass left clear
    end else begin
      fc_load <= 1'b0;
      fc_data <= ~fc_data;                                    // stale fields never held still
    end
  end
endmodule : vapc_remote_ser
`default_nettype wire

// [bench/vapc_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the path config register
module vapc_tb_top;
  import vapc_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, req, compat, fc_load, frm_en_pin; // bench nets
  logic        pix_vld, prot_en, audio_pkt_en, audio_on_pix, four_ch_en, inband_sel;              // observed levels
  logic [11:0] paddr;       // apb address
  logic [31:0] pwdata, prdata, rd, seed; // bus data and random state
  logic [23:0] pix_pin, pix_out;         // pixel pins
  logic [6:0]  req_data, fc_data;        // remote fields
  logic [7:0]  shadow, c;                // expected register value
  logic        er;                       // slave error seen
  int          failures, n_compared, cycles; // run counters

  vapc_top u_vapc_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fc_load(fc_load), .fc_data(fc_data), .frm_en_pin(frm_en_pin), .pix_pin(pix_pin), .pix_out(pix_out),
    .pix_vld(pix_vld), .prot_en(prot_en), .audio_pkt_en(audio_pkt_en), .audio_on_pix(audio_on_pix),
    .four_ch_en(four_ch_en), .inband_sel(inband_sel));
  vapc_remote_ser u_vapc_remote_ser (.clk(clk), .rst_n(rst_n), .req(req), .compat(compat),
    .req_data(req_data), .fc_load(fc_load), .fc_data(fc_data));

  // 25 ns clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // xorshift source, fixed start
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  // control levels expected for a register value
  function automatic logic [4:0] exp_ctl(input logic [7:0] v);
    return {~v[6], ~v[6], ~v[4] & ~v[6], v[3] & v[0], v[1]};
  endfunction : exp_ctl

  // valid flag and pixels expected
  function automatic logic [24:0] exp_pix(input logic [7:0] v, input logic fe, input logic [23:0] p);
    logic ok;
    ok = v[6] | (fe ^ v[5]);
    return {ok, ok ? (v[2] ? (p & 24'hfc_fcfc) : p) : 24'h00_0000};
  endfunction : exp_pix

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never reassigns psel in this time step
    @(posedge clk);
    if (n >= 50) chk(32'h0000_0000, 32'h0000_0001);
  endtask : apb

  // verdict
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  // hang guard
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles == 5000) begin
        failures++;
        wrap_up();
      end
    end
  end

  // main sequence
  initial begin
    {psel, penable, pwrite, req, compat, frm_en_pin} = 6'b00_0000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pix_pin = 24'h00_0000;
    req_data = 7'h00;
    seed = 32'h2d54_74a1;
    failures = 0;
    n_compared = 0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, VAPC_CFG_ADDR, 32'h0000_0000, rd, er);
    chk(rd, 32'h0000_0000);
    apb(1'b0, VAPC_STAT_ADDR, 32'h0000_0000, rd, er);
    chk(rd, 32'h0000_0000);
    chk(exp_ctl(8'h00), {prot_en, audio_pkt_en, audio_on_pix, four_ch_en, inband_sel});
    apb(1'b1, 12'h030, 32'h0000_00ff, rd, er);
    chk({31'h0, er}, 32'h0000_0001);
    $display("test reset_and_decode done");
    // random writes followed by remote loads, lock bit random
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      shadow = seed[7:0];
      apb(1'b1, VAPC_CFG_ADDR, {24'h00_0000, shadow}, rd, er);
      repeat (2) @(posedge clk);
      chk(exp_ctl(shadow), {prot_en, audio_pkt_en, audio_on_pix, four_ch_en, inband_sel});
      compat <= seed[8];
      req_data <= seed[15:9];
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      repeat (3) @(posedge clk);
      if (!shadow[7]) shadow[6:0] = seed[8] ? (seed[15:9] & 7'h3f) : seed[15:9];
      apb(1'b0, VAPC_CFG_ADDR, 32'h0000_0000, rd, er);
      chk(rd, {24'h00_0000, shadow});
      chk(exp_ctl(shadow), {prot_en, audio_pkt_en, audio_on_pix, four_ch_en, inband_sel});
    end
    $display("test random_remote_load done");
    // local write and remote strobe on the same edge: local wins
    fork
      apb(1'b1, VAPC_CFG_ADDR, 32'h0000_0015, rd, er);
      begin
        req_data <= 7'h6a;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
      end
    join
    apb(1'b0, VAPC_CFG_ADDR, 32'h0000_0000, rd, er);
    chk(rd, 32'h0000_0015);
    $display("test collision done");
    // every bypass, sense, depth and frame-enable combination
    for (int k = 0; k < 16; k++) begin
      seed = xs(seed);
      c = {1'b1, k[2], k[1], 2'b00, k[0], 2'b00};
      apb(1'b1, VAPC_CFG_ADDR, {24'h00_0000, c}, rd, er);
      frm_en_pin <= k[3];
      pix_pin <= seed[23:0];
      repeat (6) @(posedge clk);
      chk({pix_vld, pix_out}, exp_pix(c, k[3], seed[23:0]));
    end
    $display("test pixel_gate done");
    wrap_up();
  end
endmodule : vapc_tb_top
`default_nettype wire
